//--- urs_consts.vh
`ifndef URS_CONSTS_VH
`define URS_CONSTS_VH

// register bus
`define URS_ADDR_W      4
`define URS_DATA_W      16
`define URS_REG_STA     4'h0
`define URS_REG_MODE    4'h1
`define URS_REG_BAUD    4'h2
`define URS_REG_RXD     4'h3
`define URS_REG_IST     4'h4
`define URS_REG_IMSK    4'h5

// status and control register fields
`define URS_STA_ADET    5
`define URS_STA_IDLE    4
`define URS_STA_PAR     3
`define URS_STA_FRM     2
`define URS_STA_OVR     1
`define URS_STA_AVAIL   0

// character modes
`define URS_MODE_8N     2'h0
`define URS_MODE_8E     2'h1
`define URS_MODE_8O     2'h2
`define URS_MODE_9N     2'h3

// interrupt status and mask fields
`define URS_INT_RX      0
`define URS_INT_OVR     1
`define URS_INT_ERR     2
`define URS_INT_W       3

// reset values
`define URS_MODE_RST    2'h0
`define URS_BAUD_RST    16'h00ad
`define URS_IMSK_RST    3'h0

`endif

//--- urs_rx_shift.v
`timescale 1ns/1ps
`include "urs_consts.vh"

module urs_rx_shift
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        flush,
   input  wire        rx,
   input  wire [15:0] baud_div,
   input  wire [1:0]  mode,
   output wire        idle,
   output reg         done_r,
   output reg  [8:0]  data_r,
   output reg         parity_error_flag_r,
   output reg         framing_error_flag_r
);

   localparam S_IDLE  = 3'h0;
   localparam S_START = 3'h1;
   localparam S_DATA  = 3'h2;
   localparam S_PAR   = 3'h3;
   localparam S_STOP  = 3'h4;

   reg [2:0]  state_r;
   reg [15:0] cnt_r;
   reg [3:0]  bit_r;
   reg [8:0]  shift_r;
   reg        par_r;
   reg        par_bad_r;
   reg        rx_prev_r;

   wire       tick   = (cnt_r == 16'h0000);
   wire [15:0] reload = baud_div - 16'h0001;
   wire [3:0] last   = (mode == `URS_MODE_9N) ? 4'h8 : 4'h7;
   wire       has_par = (mode == `URS_MODE_8E) || (mode == `URS_MODE_8O);

   // receiver idle whenever no character is being assembled
   assign idle = (state_r == S_IDLE);

   // bit sampler: half a bit after the start edge, then once per bit
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r   <= S_IDLE;
         cnt_r     <= 16'h0000;
         bit_r     <= 4'h0;
         shift_r   <= 9'h000;
         par_r     <= 1'b0;
         par_bad_r <= 1'b0;
         rx_prev_r <= 1'b1;
         done_r    <= 1'b0;
         data_r    <= 9'h000;
         parity_error_flag_r    <= 1'b0;
         framing_error_flag_r    <= 1'b0;
      end
      else if (ce)
      begin
         rx_prev_r <= rx;
         done_r    <= 1'b0;
         if (flush)
            state_r <= S_IDLE;
         else if (state_r != S_IDLE && !tick)
            cnt_r <= cnt_r - 16'h0001;
         else
         begin
            case (state_r)
               S_IDLE:
               begin
                  // only a high-to-low edge starts a character, so a line
                  // held low after a framing error does not retrigger
                  if (rx_prev_r && !rx)
                  begin
                     state_r   <= S_START;
                     cnt_r     <= {1'b0, baud_div[15:1]};
                     bit_r     <= 4'h0;
                     shift_r   <= 9'h000;
                     par_r     <= 1'b0;
                     par_bad_r <= 1'b0;
                  end
               end
               S_START:
               begin
                  cnt_r   <= reload;
                  state_r <= rx ? S_IDLE : S_DATA; // glitch rejected
               end
               S_DATA:
               begin
                  cnt_r          <= reload;
                  shift_r[bit_r] <= rx;
                  par_r          <= par_r ^ rx;
                  bit_r          <= bit_r + 4'h1;
                  if (bit_r == last)
                     state_r <= has_par ? S_PAR : S_STOP;
               end
               S_PAR:
               begin
                  cnt_r     <= reload;
                  par_bad_r <= par_r ^ rx ^ (mode == `URS_MODE_8O);
                  state_r   <= S_STOP;
               end
               S_STOP:
               begin
                  done_r  <= 1'b1;
                  data_r  <= shift_r;
                  parity_error_flag_r  <= par_bad_r;
                  framing_error_flag_r  <= !rx; // stop bit must be high
                  state_r <= S_IDLE;
               end
               default:
                  state_r <= S_IDLE;
            endcase
         end
      end
   end

endmodule // urs_rx_shift

//--- urs_top.v
// How it works
// - Address detect in 9-bit mode keeps only characters with bit 8 set.
// - The receiver idle flag reads one while idle and zero while receiving.
// - The parity error flag shows the parity result of the buffer head.
// - The framing error flag shows the framing result of the buffer head.
// - The overrun flag sets on buffer overflow and stays set until cleared.
// - Clearing a set overrun flag empties the buffer and the shift register.
// - The data available flag is one while the buffer holds a character.
`timescale 1ns/1ps
`include "urs_consts.vh"

module urs_top
#(
   parameter DEPTH = 4,
   parameter PTR_W = 2
)
(
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire                   ce,
   input  wire                   rx_pin,
   input  wire [`URS_ADDR_W-1:0] addr,
   input  wire [`URS_DATA_W-1:0] wr_data,
   input  wire                   wr_en,
   input  wire                   rd_en,
   output reg  [`URS_DATA_W-1:0] rd_data,
   output reg                    irq
);

   // buffer entry: {framing error, parity error, nine data bits}
   localparam ENT_W = 11;
   localparam [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];

   // next pointer with wrap, shared by the write and read sides
   function [PTR_W-1:0] next_ptr;
      input [PTR_W-1:0] p;
      begin
         if (p == DEPTH - 1)
            next_ptr = {PTR_W{1'b0}};
         else
            next_ptr = p + 1'b1;
      end
   endfunction

   reg                  rx_meta_r;
   reg                  rx_sync_r;
   reg                  address_detect_enable_r;
   reg                  overrun_error_flag_r;
   reg [1:0]            mode_r;
   reg [15:0]           baud_r;
   reg [ENT_W-1:0]      mem_r [0:DEPTH-1];
   reg [PTR_W-1:0]      wptr_r;
   reg [PTR_W-1:0]      rptr_r;
   reg [PTR_W:0]        count_r;
   reg [`URS_INT_W-1:0] ist_r;
   reg [`URS_INT_W-1:0] imsk_r;
   reg [`URS_INT_W-1:0] ist_nxt;
   reg [`URS_DATA_W-1:0] rd_data_nxt;

   wire                 receiver_idle_flag;
   wire                 char_done;
   wire [8:0]           char_data;
   wire                 char_parity_error_flag;
   wire                 char_framing_error_flag;

   wire [ENT_W-1:0]     head = mem_r[rptr_r];
   wire                 parity_error_flag  = head[9];
   wire                 framing_error_flag = head[10];
   wire                 receive_data_available =
                           (count_r != {(PTR_W+1){1'b0}});
   wire                 full = (count_r == FULL_CNT);

   wire wr_sta  = wr_en && (addr == `URS_REG_STA);
   wire wr_mode = wr_en && (addr == `URS_REG_MODE);
   wire wr_baud = wr_en && (addr == `URS_REG_BAUD);
   wire wr_ist  = wr_en && (addr == `URS_REG_IST);
   wire wr_imsk = wr_en && (addr == `URS_REG_IMSK);
   wire rd_rxd  = rd_en && (addr == `URS_REG_RXD);

   // a one-to-zero write on the overrun flag is the flush command;
   // writing zero while it is already clear does nothing
   wire flush = wr_sta && overrun_error_flag_r
                && !wr_data[`URS_STA_OVR];

   // address filter only bites in 9-bit mode; data characters are
   // dropped so software sees just the address bytes
   wire accept = !(address_detect_enable_r
                   && (mode_r == `URS_MODE_9N)
                   && !char_data[8]);

   // nothing is stored while an overrun is pending
   wire store   = char_done && accept && !overrun_error_flag_r;
   wire push    = store && !full;
   wire ovr_evt = store && full;
   wire pop     = rd_rxd && receive_data_available && !flush;
   wire err_evt = push && (char_parity_error_flag || char_framing_error_flag);

   // two flip-flops bring the receive pin into the clock domain;
   // their reset value is the idle level, so no false start follows reset
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end
      else if (ce)
      begin
         rx_meta_r <= rx_pin;
         rx_sync_r <= rx_meta_r;
      end
   end

   // receive shift register and bit timing
   urs_rx_shift u_rx
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .flush    (flush),
      .rx       (rx_sync_r),
      .baud_div (baud_r),
      .mode     (mode_r),
      .idle     (receiver_idle_flag),
      .done_r   (char_done),
      .data_r   (char_data),
      .parity_error_flag_r   (char_parity_error_flag),
      .framing_error_flag_r   (char_framing_error_flag)
   );

   // control registers written by software
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         address_detect_enable_r <= 1'b0;
         mode_r                  <= `URS_MODE_RST;
         baud_r                  <= `URS_BAUD_RST;
         imsk_r                  <= `URS_IMSK_RST;
      end
      else if (ce)
      begin
         if (wr_sta)
            address_detect_enable_r <= wr_data[`URS_STA_ADET];
         if (wr_mode)
            mode_r <= wr_data[1:0];
         if (wr_baud)
            baud_r <= wr_data;
         if (wr_imsk)
            imsk_r <= wr_data[`URS_INT_W-1:0];
      end
   end

   // overrun flag: hardware sets, software may only clear it; an
   // overrun cannot arrive in the clearing cycle since storing is
   // blocked while the flag is set, but set is still given priority
   always @(posedge clk)
   begin
      if (!rst_n)
         overrun_error_flag_r <= 1'b0;
      else if (ce)
      begin
         if (ovr_evt)
            overrun_error_flag_r <= 1'b1;
         else if (flush)
            overrun_error_flag_r <= 1'b0;
      end
   end

   // receive buffer storage; a full buffer keeps its old entries and
   // the new character is the one lost; storage has no reset, the fill
   // count alone says which entries are valid
   always @(posedge clk)
   begin
      if (ce && push)
         mem_r[wptr_r] <= {char_framing_error_flag, char_parity_error_flag, char_data};
   end

   // write pointer; a flush rewinds it together with the read side
   always @(posedge clk)
   begin
      if (!rst_n)
         wptr_r <= {PTR_W{1'b0}};
      else if (ce)
      begin
         if (flush)
            wptr_r <= {PTR_W{1'b0}};
         else if (push)
            wptr_r <= next_ptr(wptr_r);
      end
   end

   // read pointer; only a read of a non-empty buffer advances it
   always @(posedge clk)
   begin
      if (!rst_n)
         rptr_r <= {PTR_W{1'b0}};
      else if (ce)
      begin
         if (flush)
            rptr_r <= {PTR_W{1'b0}};
         else if (pop)
            rptr_r <= next_ptr(rptr_r);
      end
   end

   // fill count; a push and a pop in one cycle leave it unchanged
   always @(posedge clk)
   begin
      if (!rst_n)
         count_r <= {(PTR_W+1){1'b0}};
      else if (ce)
      begin
         if (flush)
            count_r <= {(PTR_W+1){1'b0}};
         else if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end

   // interrupt status: sticky, write one to clear, set beats clear
   always @*
   begin
      ist_nxt = ist_r;
      if (wr_ist)
         ist_nxt = ist_nxt & ~wr_data[`URS_INT_W-1:0];
      if (push)
         ist_nxt[`URS_INT_RX] = 1'b1;
      if (ovr_evt)
         ist_nxt[`URS_INT_OVR] = 1'b1;
      if (err_evt)
         ist_nxt[`URS_INT_ERR] = 1'b1;
   end

   // interrupt line follows status and mask one cycle later; the mask
   // gates only the line, so software can still poll masked events
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         ist_r <= {`URS_INT_W{1'b0}};
         irq   <= 1'b0;
      end
      else if (ce)
      begin
         ist_r <= ist_nxt;
         irq   <= |(ist_r & imsk_r);
      end
   end

   // read mux; the data word shows the head before this read pops it;
   // error bits are forced low on an empty buffer because the head
   // slot then holds a stale or never-written entry
   always @*
   begin
      rd_data_nxt = {`URS_DATA_W{1'b0}};
      case (addr)
         `URS_REG_STA:
         begin
            rd_data_nxt[`URS_STA_ADET]  = address_detect_enable_r;
            rd_data_nxt[`URS_STA_IDLE]  = receiver_idle_flag;
            rd_data_nxt[`URS_STA_PAR]   = receive_data_available
                                          && parity_error_flag;
            rd_data_nxt[`URS_STA_FRM]   = receive_data_available
                                          && framing_error_flag;
            rd_data_nxt[`URS_STA_OVR]   = overrun_error_flag_r;
            rd_data_nxt[`URS_STA_AVAIL] = receive_data_available;
         end
         `URS_REG_MODE:
            rd_data_nxt[1:0] = mode_r;
         `URS_REG_BAUD:
            rd_data_nxt = baud_r;
         `URS_REG_RXD:
            if (receive_data_available)
               rd_data_nxt[8:0] = head[8:0];
         `URS_REG_IST:
            rd_data_nxt[`URS_INT_W-1:0] = ist_r;
         `URS_REG_IMSK:
            rd_data_nxt[`URS_INT_W-1:0] = imsk_r;
         default:
            rd_data_nxt = {`URS_DATA_W{1'b0}};
      endcase
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (!rst_n)
         rd_data <= {`URS_DATA_W{1'b0}};
      else if (ce)
      begin
         if (rd_en)
            rd_data <= rd_data_nxt;
         else
            rd_data <= {`URS_DATA_W{1'b0}};
      end
   end

endmodule // urs_top

//--- urs_top_monitor.sv
`timescale 1ns/1ps
`include "urs_consts.vh"

module urs_monitor
#(
   parameter DEPTH = 4
)
(
   input wire                   clk,
   input wire                   rst_n,
   input wire                   ce,
   input wire                   rx_pin,
   input wire [`URS_ADDR_W-1:0] addr,
   input wire [`URS_DATA_W-1:0] wr_data,
   input wire                   wr_en,
   input wire                   rd_en,
   input wire [`URS_DATA_W-1:0] rd_data,
   input wire                   irq
);
   reg  [11:0] hi_cnt_r;
   wire        rd_sta;
   wire        wr_sta;
   wire        wr_msk;

   // strobe decodes shared by several properties
   assign rd_sta = rd_en && ce && addr == `URS_REG_STA;
   assign wr_sta = wr_en && ce && addr == `URS_REG_STA;
   assign wr_msk = wr_en && ce && addr == `URS_REG_IMSK;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // quiet-line counter saturates so a long idle stretch never wraps
   always @(posedge clk)
   begin
      if (!rst_n || !rx_pin)
         hi_cnt_r <= 12'h000;
      else if (hi_cnt_r != 12'hfff)
         hi_cnt_r <= hi_cnt_r + 12'h001;
   end

   property p_rd_zero;
      ce && !rd_en |=> rd_data == 16'h0000;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");

   property p_unmapped;
      rd_en && ce && addr > `URS_REG_IMSK |=> rd_data == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");

   property p_adet_rw;
      wr_sta ##1 !wr_sta ##1 rd_sta
         |=> rd_data[5] == $past(wr_data[5], 3);
   endproperty
   a_adet_rw: assert property (p_adet_rw) else $error("adet bit");

   property p_idle_rest;
      rd_sta && hi_cnt_r == 12'hfff |=> rd_data[`URS_STA_IDLE];
   endproperty
   a_idle_rest: assert property (p_idle_rest) else $error("idle low");

   property p_empty_err;
      rd_sta |=> rd_data[`URS_STA_AVAIL] || rd_data[3:2] == 2'b00;
   endproperty
   a_empty_err: assert property (p_empty_err) else $error("err empty");

   property p_ovr_clr;
      wr_sta && !wr_data[`URS_STA_OVR] ##1 !wr_sta ##1 rd_sta
         |=> !rd_data[1];
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("ovr kept");

   property p_rxd_empty;
      rd_sta ##1 (!rd_data[0] && rd_data[4] && !rd_en)
         ##1 (rd_en && ce && addr == `URS_REG_RXD) |=> rd_data == 16'h0000;
   endproperty
   a_rxd_empty: assert property (p_rxd_empty) else $error("rxd empty");

   property p_irq_mask;
      wr_msk && wr_data[2:0] == 3'h0 ##1 ce && !wr_msk |=> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
endmodule // urs_monitor

bind urs_top urs_monitor #(.DEPTH(DEPTH)) mon_u (.clk(clk), .rst_n(rst_n),
   .ce(ce), .rx_pin(rx_pin), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .irq(irq));

//--- urs_tx_model.sv
`timescale 1ns/1ps

module urs_tx_model
#(
   parameter BIT_CLKS = 4
)
(
   input wire clk,
   output reg line
);
   initial line = 1'b1;

   // one bit held a whole bit time, changed just after an edge
   task automatic put(input logic b);
      begin
         line <= b;
         repeat (BIT_CLKS) @(posedge clk);
      end
   endtask

   // start, data lsb first, optional parity, stop, then a quiet bit time
   // so the receiver always gets back to idle between frames
   task automatic send(input logic [8:0] v, input int n, input int par,
                       input logic stp);
      int i;
      begin
         @(posedge clk);
         put(1'b0);
         for (i = 0; i < n; i++)
            put(v[i]);
         if (par != 0)
            put((^v[7:0]) ^ (par == 2));
         put(stp);
         put(1'b1);
      end
   endtask
endmodule // urs_tx_model

//--- urs_top_tb.sv
`timescale 1ns/1ps
`include "urs_consts.vh"

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   num_errors++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module urs_top_tb;
   reg         clk;
   reg         rst_n;
   reg  [3:0]  addr;
   reg  [15:0] wr_data;
   reg         wr_en;
   reg         rd_en;
   reg         ce;
   reg  [15:0] d;
   wire        rx_pin;
   wire [15:0] rd_data;
   wire        irq;
   int         num_errors;
   int         compares;

   urs_tx_model #(.BIT_CLKS(4)) tx_u (.clk(clk), .line(rx_pin));
   urs_top #(.DEPTH(4), .PTR_W(2)) dut_u (.clk(clk), .rst_n(rst_n),
      .ce(ce), .rx_pin(rx_pin), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task print_verdict;
      begin
         if (num_errors == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   task wr(input [3:0] a, input [15:0] v);
      begin
         @(posedge clk);
         wr_en   <= 1'b1;
         addr    <= a;
         wr_data <= v;
         @(posedge clk);
         wr_en <= 1'b0;
      end
   endtask

   // read data stands only in the cycle after the strobe
   task rd(input [3:0] a);
      begin
         @(posedge clk);
         rd_en <= 1'b1;
         addr  <= a;
         @(posedge clk);
         rd_en <= 1'b0;
         #1 d = rd_data;
      end
   endtask

   task rchk(input [3:0] a, input [15:0] ex, input string nm);
      begin
         rd(a);
         `CHK(nm, ex, d)
      end
   endtask

   // polls status; a character that never lands ends the run
   task wait_avail;
      int n;
      begin
         n = 0;
         d = 16'h0000;
         while (d[0] !== 1'b1 && n < 100)
         begin
            rd(`URS_REG_STA);
            n++;
         end
         if (d[0] !== 1'b1)
         begin
            num_errors++;
            print_verdict;
         end
      end
   endtask

   // reset values, idle after a long quiet line, unmapped place
   task t_reset;
      begin
         repeat (4100) @(posedge clk);
         rchk(`URS_REG_STA, 16'h0010, "sta");
         rchk(`URS_REG_MODE, 16'h0000, "mode");
         rchk(`URS_REG_BAUD, 16'h00ad, "baud");
         rchk(`URS_REG_IST, 16'h0000, "ist");
         rchk(`URS_REG_IMSK, 16'h0000, "imsk");
         wr(4'hf, 16'hffff);
         rchk(4'hf, 16'h0000, "unmapped");
         rchk(`URS_REG_STA, 16'h0010, "sta");
         wr(`URS_REG_STA, 16'h0020);
         rchk(`URS_REG_STA, 16'h0030, "adet");
         wr(`URS_REG_STA, 16'h0000);
      end
   endtask

   // every character mode; busy mid-frame, head checked then popped
   task t_modes;
      int m;
      logic [8:0] v;
      begin
         wr(`URS_REG_BAUD, 16'h0004);
         wr(`URS_REG_IMSK, 16'h0000);
         for (m = 0; m < 4; m++)
         begin
            v = 9'h1a5 ^ m[8:0];
            wr(`URS_REG_MODE, m[15:0]);
            fork
               tx_u.send(v, (m == 3) ? 9 : 8, m % 3, 1'b1);
            join_none
            repeat (12) @(posedge clk);
            rd(`URS_REG_STA);
            `CHK("busy", 1'b0, d[4])
            wait_avail;
            rchk(`URS_REG_STA, 16'h0011, "sta");
            rchk(`URS_REG_RXD, {7'h00, (m == 3) ? v : {1'b0, v[7:0]}},
                 "rxd");
            rchk(`URS_REG_STA, 16'h0010, "sta");
            rchk(`URS_REG_RXD, 16'h0000, "rxd");
            wait fork;
         end
      end
   endtask

   // bad parity, then a low stop bit; the error event drives irq
   task t_errors;
      begin
         wr(`URS_REG_IST, 16'h0007);
         wr(`URS_REG_MODE, 16'h0001);
         tx_u.send(9'h03c, 8, 2, 1'b1);
         wait_avail;
         rchk(`URS_REG_STA, 16'h0019, "sta");
         rchk(`URS_REG_RXD, 16'h003c, "rxd");
         rchk(`URS_REG_STA, 16'h0010, "sta");
         wr(`URS_REG_MODE, 16'h0000);
         tx_u.send(9'h043, 8, 0, 1'b0);
         wait_avail;
         rchk(`URS_REG_STA, 16'h0015, "sta");
         rchk(`URS_REG_IST, 16'h0005, "ist");
         `CHK("irq", 1'b0, irq)
         wr(`URS_REG_IMSK, 16'h0004);
         rchk(`URS_REG_IST, 16'h0005, "ist");
         `CHK("irq", 1'b1, irq)
         wr(`URS_REG_IST, 16'h0004);
         rchk(`URS_REG_RXD, 16'h0043, "rxd");
         `CHK("irq", 1'b0, irq)
         wr(`URS_REG_IMSK, 16'h0000);
      end
   endtask

   // five characters into four places, then clear the flag
   task t_overrun;
      int i;
      begin
         for (i = 0; i < 5; i++)
            tx_u.send(9'h010 + i[8:0], 8, 0, 1'b1);
         repeat (8) @(posedge clk);
         rchk(`URS_REG_STA, 16'h0013, "sta");
         rchk(`URS_REG_IST, 16'h0003, "ist");
         wr(`URS_REG_IST, 16'h0007);
         rchk(`URS_REG_RXD, 16'h0010, "rxd");
         tx_u.send(9'h0ee, 8, 0, 1'b1);
         repeat (8) @(posedge clk);
         rd(`URS_REG_IST);
         `CHK("ist_rx", 1'b0, d[0])
         rchk(`URS_REG_RXD, 16'h0011, "rxd");
         rchk(`URS_REG_STA, 16'h0013, "sta");
         wr(`URS_REG_STA, 16'h0000);
         rchk(`URS_REG_STA, 16'h0010, "sta");
         rchk(`URS_REG_RXD, 16'h0000, "rxd");
         tx_u.send(9'h077, 8, 0, 1'b1);
         wait_avail;
         rchk(`URS_REG_RXD, 16'h0077, "rxd");
      end
   endtask

   // address detect acts only in nine-bit mode
   task t_adet;
      begin
         wr(`URS_REG_MODE, 16'h0003);
         wr(`URS_REG_STA, 16'h0020);
         tx_u.send(9'h055, 9, 0, 1'b1);
         repeat (8) @(posedge clk);
         rchk(`URS_REG_STA, 16'h0030, "sta");
         tx_u.send(9'h1a5, 9, 0, 1'b1);
         wait_avail;
         rchk(`URS_REG_RXD, 16'h01a5, "rxd");
         wr(`URS_REG_MODE, 16'h0000);
         tx_u.send(9'h055, 8, 0, 1'b1);
         wait_avail;
         rchk(`URS_REG_RXD, 16'h0055, "rxd");
      end
   endtask

   // a low enable freezes all state, so a write in that time is lost
   task t_freeze;
      begin
         @(posedge clk);
         ce <= 1'b0;
         wr(`URS_REG_MODE, 16'h0002);
         @(posedge clk);
         ce <= 1'b1;
         rchk(`URS_REG_MODE, 16'h0000, "frozen");
      end
   endtask

   initial
   begin
      num_errors = 0;
      compares   = 0;
      rst_n      = 1'b0;
      addr       = 4'h0;
      wr_data    = 16'h0000;
      wr_en      = 1'b0;
      rd_en      = 1'b0;
      ce         = 1'b1;
      d          = 16'h0000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_modes;
      t_errors;
      t_overrun;
      t_adet;
      t_freeze;
      print_verdict;
   end
endmodule // urs_top_tb
